// ==== common/pfsr_cfg.svh ====
// Command codes, field positions, reset values and identity constants of the status bank
`ifndef PFSR_CFG_SVH
`define PFSR_CFG_SVH

// ---------------------------------------------------------------
// Command codes of the readable registers
// ---------------------------------------------------------------
`define PFSR_CMD_STATUS_BYTE 8'h78
`define PFSR_CMD_SUMMARY 8'h79
`define PFSR_CMD_VOUT_FLAGS 8'h7a
`define PFSR_CMD_INPUT_FLAGS 8'h7c
`define PFSR_CMD_THERMAL_FLAGS 8'h7d
`define PFSR_CMD_VIN_READ 8'h88
`define PFSR_CMD_IIN_READ 8'h89
`define PFSR_CMD_VOUT_READ 8'h8b
`define PFSR_CMD_PIN_READ 8'h97
`define PFSR_CMD_REVISION 8'h98
`define PFSR_CMD_MAKER 8'h99

// ---------------------------------------------------------------
// Summary word bit positions
// ---------------------------------------------------------------
`define PFSR_SW_VOUT 15
`define PFSR_SW_OUTPUT_CURRENT_POWER_SUMMARY 14
`define PFSR_SW_INPUT 13
`define PFSR_SW_MAKER 12
`define PFSR_SW_PGOOD_N 11
`define PFSR_SW_AIRFLOW 10
`define PFSR_SW_OTHER 9
`define PFSR_SW_UNLISTED_HI 8
`define PFSR_SW_BUSY 7
`define PFSR_SW_OFF 6
`define PFSR_SW_OUTPUT_OVERVOLTAGE_SUMMARY 5
`define PFSR_SW_OUTPUT_OVERCURRENT_SUMMARY 4
`define PFSR_SW_INPUT_UNDERVOLTAGE_SUMMARY 3
`define PFSR_SW_TEMP 2
`define PFSR_SW_CML 1
`define PFSR_SW_UNLISTED_LO 0

// ---------------------------------------------------------------
// Linear format fields and exponent sources
// ---------------------------------------------------------------
`define PFSR_LIN_EXP_HI 15
`define PFSR_LIN_EXP_LO 11
`define PFSR_EXPCFG_VIN_HI 5
`define PFSR_EXPCFG_VIN_LO 3
`define PFSR_EXPCFG_IIN_HI 10
`define PFSR_EXPCFG_IIN_LO 6
`define PFSR_EXPCFG_PIN_HI 2
`define PFSR_EXPCFG_PIN_LO 0
`define PFSR_VMODE_EXP_HI 2
`define PFSR_VMODE_EXP_LO 0

// ---------------------------------------------------------------
// Channel indexes and reset values
// ---------------------------------------------------------------
`define PFSR_CH_VIN 0
`define PFSR_CH_IIN 1
`define PFSR_CH_VOUT 2
`define PFSR_CH_PIN 3
`define PFSR_RST_BYTE 8'h00
`define PFSR_RST_WORD 16'h0000
`define PFSR_REVISION_DEF 8'h11
// Arbitrary neutral identity value
`define PFSR_MAKER_DEF 8'h5a

`endif

// ==== common/pfsr_pkg.sv ====
// Types shared by the status and telemetry register bank
`default_nettype none
package pfsr_pkg;
   // Live fault and warning conditions from the controller
   typedef struct packed {
      logic out_overvolt_fault;
      logic out_overvolt_warning;
      logic out_undervolt_warning;
      logic out_undervolt_fault;
      logic in_overvolt_fault;
      logic in_undervolt_warning;
      logic in_undervolt_fault;
      logic input_below_turnoff;
      logic in_overcurrent_fault;
      logic in_overcurrent_warning;
      logic in_overpower_warning;
      logic overtemp_fault;
      logic overtemp_warning;
      logic out_overcurrent_fault;
      logic out_current_power_other;
      logic maker_specific_summary;
      logic airflow_summary;
      logic comm_memory_logic_fault;
      logic unlisted_event;
   } pfsr_cond_t;

   // One readback in linear format
   typedef struct packed {
      logic [4:0] exponent;
      logic [10:0] mantissa;
   } pfsr_linear_t;

   // Answer to a register read
   typedef struct packed {
      logic valid;
      logic unmapped;
      logic wide;
      logic [15:0] data;
   } pfsr_answer_t;
endpackage : pfsr_pkg
`default_nettype wire

// ==== design/pfsr_status_bank.sv ====
// Read-only fault status and telemetry register bank addressed by command code
//
// Summary of operation
// - Summary bits 15..12 flag output, current, input, maker
// - Summary bit 11 set while power not good
// - Summary bit 10 flags airflow fault or warning
// - Summary bit 8 flags events outside bits 15..1
// - Bit 7 busy, bit 6 output off
// - Bits 5,4,3: output OV, output OC, input UV
// - Bit 2 temperature, bit 1 comm/memory/logic
// - Bit 0 flags events outside bits 7..1
// - Output voltage flags in bits 7..4
// - Input flags bits 7, 5, 4
// - Input flag bit 3: below turn-off voltage
// - Input flags bits 2, 1, 0: current, power
// - Thermal flags bits 7, 6; rest reserved zero
// - Readback: exponent 15..11, mantissa 10..0
// - Input voltage exponent from config bits 5..3
// - Input current exponent from config bits 10..6
// - Input power exponent from config bits 2..0
// - Output voltage exponent from mode bits, signed
// - Fixed protocol revision byte
// - Fixed maker identification byte
// - Status byte mirrors summary low byte
`include "pfsr_cfg.svh"
`default_nettype none
module pfsr_status_bank #(
   parameter logic [7:0] REVISION = `PFSR_REVISION_DEF,
   parameter logic [7:0] MAKER_CODE = `PFSR_MAKER_DEF,
   parameter int CHANNELS = 4
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire pfsr_pkg::pfsr_cond_t cond,
   input wire logic power_good,
   input wire logic output_on,
   input wire logic busy_event,
   input wire logic clear_busy,
   input wire logic [15:0] exp_config,
   input wire logic [7:0] output_voltage_format_config,
   input wire logic [CHANNELS-1:0][10:0] meas_mantissa,
   input wire logic [CHANNELS-1:0] meas_update,
   input wire logic rd_req,
   input wire logic [7:0] rd_cmd,
   output var pfsr_pkg::pfsr_answer_t rd_answer,
   output logic [15:0] summary_word
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [15:0] summary_r; // Registered summary word
   logic [15:0] summary_nxt; // Next summary word
   logic [7:0] vout_flags_r; // Output voltage flag byte
   logic [7:0] vout_flags_nxt;
   logic [7:0] input_flags_r; // Input flag byte
   logic [7:0] input_flags_nxt;
   logic [7:0] thermal_r; // Thermal flag byte
   logic [7:0] thermal_nxt;
   logic busy_r; // Sticky busy flag
   logic busy_nxt;
   logic vout_any; // Any output voltage flag
   logic input_any; // Any input flag
   logic temp_any; // Any thermal flag
   logic iout_any; // Any output current or power flag
   logic unlisted_lo; // Active event outside bits 7..1
   // Captured readbacks; unpacked so each capture process owns its own entry
   pfsr_pkg::pfsr_linear_t reading_r [CHANNELS];
   logic [CHANNELS-1:0][4:0] exp_src; // Exponent for each channel
   pfsr_pkg::pfsr_answer_t answer_r; // Registered read answer
   pfsr_pkg::pfsr_answer_t answer_nxt;

   // ---------------------------------------------------------------
   // Detailed flag bytes
   // ---------------------------------------------------------------

   // Compose the three detailed flag bytes from live conditions
   always_comb begin
      vout_flags_nxt = `PFSR_RST_BYTE;
      vout_flags_nxt[7] = cond.out_overvolt_fault;
      vout_flags_nxt[6] = cond.out_overvolt_warning;
      vout_flags_nxt[5] = cond.out_undervolt_warning;
      vout_flags_nxt[4] = cond.out_undervolt_fault;
      input_flags_nxt = `PFSR_RST_BYTE;
      input_flags_nxt[7] = cond.in_overvolt_fault;
      input_flags_nxt[5] = cond.in_undervolt_warning;
      input_flags_nxt[4] = cond.in_undervolt_fault;
      input_flags_nxt[3] = cond.input_below_turnoff;
      input_flags_nxt[2] = cond.in_overcurrent_fault;
      input_flags_nxt[1] = cond.in_overcurrent_warning;
      input_flags_nxt[0] = cond.in_overpower_warning;
      // Reserved thermal bits stay zero
      thermal_nxt = `PFSR_RST_BYTE;
      thermal_nxt[7] = cond.overtemp_fault;
      thermal_nxt[6] = cond.overtemp_warning;
   end

   // Category summaries feeding the word
   assign vout_any = |vout_flags_nxt;
   assign input_any = |input_flags_nxt;
   assign temp_any = |thermal_nxt;
   assign iout_any = cond.out_overcurrent_fault | cond.out_current_power_other;

   // Events that the low byte cannot name individually
   // A warning stays unlisted even when a listed fault is active beside it
   assign unlisted_lo = (|vout_flags_nxt[6:4]) | cond.out_current_power_other
      | input_flags_nxt[7] | input_flags_nxt[5] | (|input_flags_nxt[3:0])
      | cond.maker_specific_summary | cond.airflow_summary
      | cond.unlisted_event;

   // ---------------------------------------------------------------
   // Sticky busy flag
   // ---------------------------------------------------------------

   // Set wins over clear so no busy event is lost
   assign busy_nxt = busy_event | (busy_r & ~clear_busy);

   // Hold the busy flag
   always_ff @(posedge clock) begin
      if (rst) begin
         busy_r <= 1'b0;
      end else if (ce) begin
         busy_r <= busy_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Summary word
   // ---------------------------------------------------------------

   // Build the sixteen summary bits
   always_comb begin
      summary_nxt = `PFSR_RST_WORD;
      summary_nxt[`PFSR_SW_VOUT] = vout_any;
      summary_nxt[`PFSR_SW_OUTPUT_CURRENT_POWER_SUMMARY] = iout_any;
      summary_nxt[`PFSR_SW_INPUT] = input_any;
      summary_nxt[`PFSR_SW_MAKER] = cond.maker_specific_summary;
      summary_nxt[`PFSR_SW_PGOOD_N] = ~power_good;
      summary_nxt[`PFSR_SW_AIRFLOW] = cond.airflow_summary;
      summary_nxt[`PFSR_SW_OTHER] = 1'b0;
      summary_nxt[`PFSR_SW_UNLISTED_HI] = cond.unlisted_event;
      summary_nxt[`PFSR_SW_BUSY] = busy_nxt;
      summary_nxt[`PFSR_SW_OFF] = ~output_on;
      summary_nxt[`PFSR_SW_OUTPUT_OVERVOLTAGE_SUMMARY] = cond.out_overvolt_fault;
      summary_nxt[`PFSR_SW_OUTPUT_OVERCURRENT_SUMMARY] = cond.out_overcurrent_fault;
      summary_nxt[`PFSR_SW_INPUT_UNDERVOLTAGE_SUMMARY] = cond.in_undervolt_fault;
      summary_nxt[`PFSR_SW_TEMP] = temp_any;
      summary_nxt[`PFSR_SW_CML] = cond.comm_memory_logic_fault;
      summary_nxt[`PFSR_SW_UNLISTED_LO] = unlisted_lo;
   end

   // Register the summary word and flag bytes together
   always_ff @(posedge clock) begin
      if (rst) begin
         summary_r <= `PFSR_RST_WORD;
         vout_flags_r <= `PFSR_RST_BYTE;
         input_flags_r <= `PFSR_RST_BYTE;
         thermal_r <= `PFSR_RST_BYTE;
      end else if (ce) begin
         summary_r <= summary_nxt;
         vout_flags_r <= vout_flags_nxt;
         input_flags_r <= input_flags_nxt;
         thermal_r <= thermal_nxt;
      end
   end

   assign summary_word = summary_r;

   // ---------------------------------------------------------------
   // Measurement readbacks
   // ---------------------------------------------------------------

   // Exponent source for each channel
   always_comb begin
      exp_src = '0;
      exp_src[`PFSR_CH_VIN] = {2'b00,
         exp_config[`PFSR_EXPCFG_VIN_HI:`PFSR_EXPCFG_VIN_LO]};
      exp_src[`PFSR_CH_IIN] =
         exp_config[`PFSR_EXPCFG_IIN_HI:`PFSR_EXPCFG_IIN_LO];
      // Mode field is signed, so extend its sign
      exp_src[`PFSR_CH_VOUT] = {{2{output_voltage_format_config[`PFSR_VMODE_EXP_HI]}},
         output_voltage_format_config[`PFSR_VMODE_EXP_HI:`PFSR_VMODE_EXP_LO]};
      exp_src[`PFSR_CH_PIN] = {2'b00,
         exp_config[`PFSR_EXPCFG_PIN_HI:`PFSR_EXPCFG_PIN_LO]};
   end

   // Capture exponent and mantissa in one edge per update
   for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_capture
      always_ff @(posedge clock) begin
         if (rst) begin
            reading_r[ch] <= `PFSR_RST_WORD;
         end else if (ce && meas_update[ch]) begin
            reading_r[ch].exponent <= exp_src[ch];
            reading_r[ch].mantissa <= meas_mantissa[ch];
         end
      end
   end

   // ---------------------------------------------------------------
   // Register read port
   // ---------------------------------------------------------------

   // Decode the command code into an answer
   always_comb begin
      answer_nxt = '0;
      answer_nxt.valid = rd_req;
      case (rd_cmd)
         `PFSR_CMD_STATUS_BYTE: begin
            answer_nxt.data = {8'h00, summary_r[7:0]};
         end
         `PFSR_CMD_SUMMARY: begin
            answer_nxt.wide = 1'b1;
            answer_nxt.data = summary_r;
         end
         `PFSR_CMD_VOUT_FLAGS: begin
            answer_nxt.data = {8'h00, vout_flags_r};
         end
         `PFSR_CMD_INPUT_FLAGS: begin
            answer_nxt.data = {8'h00, input_flags_r};
         end
         `PFSR_CMD_THERMAL_FLAGS: begin
            answer_nxt.data = {8'h00, thermal_r};
         end
         `PFSR_CMD_VIN_READ: begin
            answer_nxt.wide = 1'b1;
            answer_nxt.data = reading_r[`PFSR_CH_VIN];
         end
         `PFSR_CMD_IIN_READ: begin
            answer_nxt.wide = 1'b1;
            answer_nxt.data = reading_r[`PFSR_CH_IIN];
         end
         `PFSR_CMD_VOUT_READ: begin
            answer_nxt.wide = 1'b1;
            answer_nxt.data = reading_r[`PFSR_CH_VOUT];
         end
         `PFSR_CMD_PIN_READ: begin
            answer_nxt.wide = 1'b1;
            answer_nxt.data = reading_r[`PFSR_CH_PIN];
         end
         `PFSR_CMD_REVISION: begin
            answer_nxt.data = {8'h00, REVISION};
         end
         `PFSR_CMD_MAKER: begin
            answer_nxt.data = {8'h00, MAKER_CODE};
         end
         default: begin
            // Any unmapped code answers zero with the unmapped mark
            answer_nxt.unmapped = rd_req;
         end
      endcase
      if (!rd_req) begin
         answer_nxt = '0;
      end
   end

   // Register the answer one cycle after the request
   always_ff @(posedge clock) begin
      if (rst) begin
         answer_r <= '0;
      end else if (ce) begin
         answer_r <= answer_nxt;
      end
   end

   assign rd_answer = answer_r;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   a_output_overvoltage_summary_summary: assert property (ce && cond.out_overvolt_fault |=>
      summary_r[15] && summary_r[5] && vout_flags_r[7])
      else $error("output overvoltage not reflected in summary");

   a_pgood_neg: assert property (ce && !power_good |=> summary_r[11])
      else $error("power good negation not shown");

   a_other_zero: assert property (summary_r[9] == 1'b0)
      else $error("other bit not zero");

   a_busy_sticky: assert property (ce && busy_event |=>
      summary_r[7] && busy_r)
      else $error("busy event lost");

   a_airflow_low: assert property (ce && cond.airflow_summary |=>
      summary_r[10] && summary_r[0])
      else $error("airflow not in bits 10 and 0");

   // Category bits must agree with the flag bytes registered beside them
   a_input_or: assert property (summary_r[13] == (|input_flags_r)
      && summary_r[15] == (|vout_flags_r))
      else $error("category bits differ from flag bytes");

   // Temperature bit tracks the registered thermal byte
   a_temp_bit: assert property (summary_r[2] == (|thermal_r[7:6]))
      else $error("temperature bit differs from thermal flags");

   // Bit 8 follows the unlisted event one edge later
   a_unlisted_hi: assert property (ce |=> summary_r[8] == $past(cond.unlisted_event))
      else $error("unlisted event bit wrong");

   // Overvoltage warning is never named in bits 7..1, even beside the fault
   a_warn_unlisted: assert property (ce && cond.out_overvolt_warning |=> summary_r[0])
      else $error("unlisted warning not in bit 0");

   a_thermal_rsvd: assert property (thermal_r[5:0] == 6'h00)
      else $error("reserved thermal bits not zero");

   a_byte_mirror: assert property (ce && rd_req && rd_cmd == `PFSR_CMD_STATUS_BYTE |=>
      rd_answer.valid && rd_answer.data == {8'h00, $past(summary_r[7:0])})
      else $error("status byte does not mirror summary");

   a_vin_exp: assert property (ce && meas_update[0] |=>
      reading_r[0].exponent == {2'b00, $past(exp_config[5:3])}
      && reading_r[0].mantissa == $past(meas_mantissa[0]))
      else $error("input voltage capture wrong");

   a_vout_exp_sign: assert property (ce && meas_update[2] |=>
      reading_r[2].exponent == {{2{$past(output_voltage_format_config[2])}},
      $past(output_voltage_format_config[2:0])})
      else $error("output voltage exponent not sign extended");

   a_hold_reading: assert property (!(ce && meas_update[1]) |=>
      $stable(reading_r[1]))
      else $error("reading changed without update");

   a_unmapped_ans: assert property (ce && rd_req && rd_cmd == 8'h00 |=>
      rd_answer.valid && rd_answer.unmapped && rd_answer.data == 16'h0000)
      else $error("unmapped code not marked");

   c_word_read: cover property (ce && rd_req && rd_cmd == `PFSR_CMD_SUMMARY ##1 rd_answer.valid);
   c_busy_clear: cover property (ce && busy_event ##1 ce && clear_busy ##1 !busy_r);
   c_pin_read: cover property (ce && meas_update[3] ##1
      ce && rd_req && rd_cmd == `PFSR_CMD_PIN_READ);
   // Unmapped code read and loss of power good
   c_unmapped_read: cover property (ce && rd_req && rd_cmd == 8'hff ##1 rd_answer.unmapped);
   c_power_lost: cover property (ce && !power_good ##1 summary_r[11]);

endmodule : pfsr_status_bank
`default_nettype wire

// ==== bench/pfsr_host_model.sv ====
// Host model that issues register reads and notes the expected answers
`default_nettype none
module pfsr_host_model (
   input wire logic clock,
   output logic rd_req,
   output logic [7:0] rd_cmd
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Expected answers, oldest first: {unmapped, wide, data}
   // ------------------------------------------------------------
   logic [17:0] exp_q[$];
   // Idle bus at time zero
   initial begin
      rd_req = 1'b0;
      rd_cmd = 8'h00;
   end
   // One read, entered at a falling edge; gap idle cycles model a slow host
   task automatic read(input logic [7:0] cmd, input logic [17:0] expv, input int gap);
      rd_req = 1'b1;
      rd_cmd = cmd;
      exp_q.push_back(expv);
      @(negedge clock);
      if (gap > 0) begin
         // Released code wiggles so a stale value is never mistaken
         rd_req = 1'b0;
         rd_cmd = ~cmd;
         repeat (gap) @(negedge clock);
      end
   endtask : read
endmodule : pfsr_host_model
`default_nettype wire

// ==== bench/tb_pmbus_status_telemetry_regs.sv ====
// Self-checking bench of the status and telemetry register bank
`include "pfsr_cfg.svh"
`default_nettype none
module tb_pmbus_status_telemetry_regs;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam logic [7:0] REV = 8'h23; // Arbitrary test value
   localparam logic [7:0] MAKER = 8'h3c; // Arbitrary test value
   logic clock, rst, ce, power_good, output_on, busy_event, clear_busy;
   pfsr_pkg::pfsr_cond_t cond;
   logic [15:0] exp_config;
   logic [7:0] vmode;
   logic [3:0][10:0] mant;
   logic [3:0] meas_update;
   logic rd_req;
   logic [7:0] rd_cmd;
   pfsr_pkg::pfsr_answer_t rd_answer;
   logic [15:0] summary_word, s;
   logic [31:0] seed, r;
   logic [15:0] rdg[4]; // Expected readings per channel
   logic bz; // Expected busy flag
   logic [17:0] a_exp, a_got;
   int num_errors, n_tests;
   // ------------------------------------------------------------
   // Design and host
   // ------------------------------------------------------------
   pfsr_status_bank #(.REVISION(REV), .MAKER_CODE(MAKER), .CHANNELS(4)) dut (
      .clock(clock), .rst(rst), .ce(ce), .cond(cond), .power_good(power_good),
      .output_on(output_on), .busy_event(busy_event), .clear_busy(clear_busy),
      .exp_config(exp_config), .output_voltage_format_config(vmode),
      .meas_mantissa(mant), .meas_update(meas_update), .rd_req(rd_req), .rd_cmd(rd_cmd),
      .rd_answer(rd_answer), .summary_word(summary_word));
   pfsr_host_model host (.clock(clock), .rd_req(rd_req), .rd_cmd(rd_cmd));
   // Clock, 40 ns period
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction : xs
   function automatic logic [7:0] vflags(input pfsr_pkg::pfsr_cond_t c);
      return {c.out_overvolt_fault, c.out_overvolt_warning, c.out_undervolt_warning,
         c.out_undervolt_fault, 4'h0};
   endfunction : vflags
   function automatic logic [7:0] iflags(input pfsr_pkg::pfsr_cond_t c);
      return {c.in_overvolt_fault, 1'b0, c.in_undervolt_warning, c.in_undervolt_fault,
         c.input_below_turnoff, c.in_overcurrent_fault, c.in_overcurrent_warning,
         c.in_overpower_warning};
   endfunction : iflags
   // Expected summary word; bit 9 stays zero
   function automatic logic [15:0] exp_sum(input pfsr_pkg::pfsr_cond_t c, input logic pg,
      input logic on, input logic b);
      logic [7:0] v;
      logic [7:0] i;
      logic [15:0] w;
      v = vflags(c);
      i = iflags(c);
      w = {|v, c.out_overcurrent_fault | c.out_current_power_other, |i,
         c.maker_specific_summary, ~pg, c.airflow_summary, 1'b0, c.unlisted_event, b, ~on,
         c.out_overvolt_fault, c.out_overcurrent_fault, c.in_undervolt_fault,
         c.overtemp_fault | c.overtemp_warning, c.comm_memory_logic_fault, 1'b0};
      w[0] = (|v[6:4]) | c.out_current_power_other | (|{i[7], i[5], i[3:0]})
         | c.maker_specific_summary | c.airflow_summary | c.unlisted_event;
      return w;
   endfunction : exp_sum
   // Compare of one read answer
   task automatic check_ans(input logic [17:0] e, input logic [17:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %0t answer exp %h got %h", $time, e, g);
      end
   endtask : check_ans
   // Compare of one word
   task automatic check_word(input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %0t word exp %h got %h", $time, e, g);
      end
   endtask : check_word
   task automatic summarize();
      $display("Errors %0d of %0d comparisons", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize
   // Answer watcher: each valid answer takes the oldest note
   always @(posedge clock) begin
      #1;
      if (rd_answer.valid === 1'b1) begin
         a_got = rd_answer[17:0];
         a_exp = (host.exp_q.size() > 0) ? host.exp_q.pop_front() : 18'h3ffff;
         check_ans(a_exp, a_got);
      end
   end
   // Watchdog
   initial begin
      #400000;
      num_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      summarize();
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      num_errors = 0;
      n_tests = 0;
      seed = 32'h22217e79;
      bz = 1'b0;
      rdg = '{default: 16'h0000};
      rst = 1'b1;
      ce = 1'b1;
      cond = '0;
      power_good = 1'b1;
      output_on = 1'b1;
      busy_event = 1'b0;
      clear_busy = 1'b0;
      exp_config = 16'h0000;
      vmode = 8'h00;
      mant = '0;
      meas_update = 4'h0;
      repeat (2) @(negedge clock);
      check_word(16'h0000, summary_word);
      check_ans(18'h00000, rd_answer[17:0]);
      rst = 1'b0;
      // Single condition walk, then sparse random conditions
      for (int k = 0; k < 40; k++) begin
         seed = xs(seed);
         r = seed;
         seed = xs(seed);
         cond = (k < 19) ? 19'h00001 << k : r[18:0] & seed[18:0];
         power_good = (k < 19) | seed[20];
         output_on = (k < 19) | seed[21];
         busy_event = (k >= 19) & seed[22] & seed[23];
         clear_busy = (k >= 19) & seed[24];
         bz = busy_event | (bz & ~clear_busy);
         s = exp_sum(cond, power_good, output_on, bz);
         repeat (2) @(negedge clock);
         check_word(s, summary_word);
         host.read(`PFSR_CMD_SUMMARY, {2'b01, s}, 0);
         host.read(`PFSR_CMD_STATUS_BYTE, {10'h000, s[7:0]}, 0);
         host.read(`PFSR_CMD_VOUT_FLAGS, {10'h000, vflags(cond)}, 0);
         host.read(`PFSR_CMD_INPUT_FLAGS, {10'h000, iflags(cond)}, 0);
         host.read(`PFSR_CMD_THERMAL_FLAGS, {10'h000, cond.overtemp_fault,
            cond.overtemp_warning, 6'h00}, 1 + k % 2);
      end
      // Clock enable low freezes the summary
      ce = 1'b0;
      cond = ~cond;
      repeat (2) @(negedge clock);
      check_word(s, summary_word);
      ce = 1'b1;
      repeat (2) @(negedge clock);
      check_word(exp_sum(cond, power_good, output_on, bz), summary_word);
      // Readbacks; inputs move after capture and must not leak in
      for (int k = 0; k < 12; k++) begin
         seed = xs(seed);
         r = xs(seed);
         meas_update = seed[3:0];
         exp_config = seed[31:16];
         vmode = seed[11:4];
         mant = {r, seed[11:0]};
         if (meas_update[0]) rdg[0] = {2'b00, exp_config[5:3], mant[0]};
         if (meas_update[1]) rdg[1] = {exp_config[10:6], mant[1]};
         if (meas_update[2]) rdg[2] = {{2{vmode[2]}}, vmode[2:0], mant[2]};
         if (meas_update[3]) rdg[3] = {2'b00, exp_config[2:0], mant[3]};
         @(negedge clock);
         meas_update = 4'h0;
         exp_config = ~exp_config;
         vmode = ~vmode;
         mant = ~mant;
         host.read(`PFSR_CMD_VIN_READ, {2'b01, rdg[0]}, 0);
         host.read(`PFSR_CMD_IIN_READ, {2'b01, rdg[1]}, 0);
         host.read(`PFSR_CMD_VOUT_READ, {2'b01, rdg[2]}, 0);
         host.read(`PFSR_CMD_PIN_READ, {2'b01, rdg[3]}, 1 + k % 3);
      end
      // Fixed bytes and unmapped codes
      host.read(`PFSR_CMD_REVISION, {10'h000, REV}, 0);
      host.read(`PFSR_CMD_MAKER, {10'h000, MAKER}, 0);
      host.read(8'h7b, {2'b10, 16'h0000}, 0);
      host.read(8'hff, {2'b10, 16'h0000}, 3);
      check_word(16'h0000, 16'(host.exp_q.size()));
      summarize();
   end
endmodule : tb_pmbus_status_telemetry_regs
`default_nettype wire
